// [rtl/hftu_pkg.sv]
// Constants shared by the host FIFO tag unpacker files.
package hftu_pkg;
  // APB byte addresses; the whole low 4 KB is the FIFO port window.
  localparam logic [15:0] FIFO_WIN_BASE = 16'h0000;
  localparam int FIFO_WIN_MSB = 15;
  localparam int FIFO_WIN_LSB = 12;
  localparam logic [3:0] FIFO_WIN_SEL = 4'h0;
  localparam logic [15:0] DMA_BUFFER_BASE_OFS = 16'h1000;
  localparam logic [15:0] DMA_WORD_COUNT_OFS = 16'h1004;
  localparam logic [15:0] IRQ_ENABLE_REG_OFS = 16'h1008;
  localparam logic [15:0] IRQ_FLAG_REG_OFS = 16'h100c;
  localparam logic [15:0] OUTPUT_CATEGORY_FILTER_OFS = 16'h1010;
  localparam logic [15:0] INPUT_QUEUE_FREE_OFS = 16'h1014;
  localparam logic [15:0] OUTPUT_QUEUE_WORDS_OFS = 16'h1018;
  // Field layout of a tag-description word.
  localparam int TAG_W = 9;
  localparam int GRP_MSB = 8;
  localparam int GRP_LSB = 4;
  localparam int POS_W = 4;
  localparam int FMT_MSB = 15;
  localparam int FMT_LSB = 14;
  localparam int CNT_MSB = 31;
  localparam int CNT_LSB = 16;
  localparam logic [1:0] FMT_HOLD = 2'h0;
  localparam logic [1:0] FMT_INC = 2'h1;
  localparam logic [1:0] FMT_IDX = 2'h2;
  // Bit positions inside the interrupt and filter registers.
  localparam int DMA_IRQ_BIT = 0;
  localparam int FILT_TAG_BIT = 0;
  localparam int FILT_DATA_BIT = 1;
  localparam int DMA_CNT_W = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] DMA_ADDR_STEP = 32'h0000_0004;
endpackage

// [rtl/hftu_word_if.sv]
// Word stream into the unpacker and tag/data pairs out of it.
`timescale 1ns/1ps
interface hftu_word_if;
  logic word_valid;
  logic [31:0] word;
  logic word_ready;
  logic pair_valid;
  logic [8:0] pair_tag;
  logic [31:0] pair_data;
  logic pair_ready;
  modport src (output word_valid, output word, output pair_ready,
    input word_ready, input pair_valid, input pair_tag, input pair_data);
  modport unp (input word_valid, input word, input pair_ready,
    output word_ready, output pair_valid, output pair_tag,
    output pair_data);
endinterface

// [rtl/hftu_unpack.sv]
// Turns description words plus data words into tag/data pairs.
`timescale 1ns/1ps
module hftu_unpack (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  hftu_word_if.unp w
);
  typedef enum logic [3:0] {
    ST_DESC = 4'h1,
    ST_HOLD = 4'h2,
    ST_INC = 4'h4,
    ST_IDX = 4'h8
  } hftu_ust_t;

  hftu_ust_t st_r, st_nxt;
  logic [8:0] tag_r, tag_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] mask_r, mask_nxt;

  // Lowest set mask bit gives the next in-group position.
  function automatic logic [3:0] hftu_low_pos(input logic [15:0] m);
    logic [3:0] p;
    p = 4'hf;
    for (int i = 15; i >= 0; i--) begin
      if (m[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  wire [1:0] fmt = w.word[hftu_pkg::FMT_MSB:hftu_pkg::FMT_LSB]; // RULE27
  wire [15:0] hi = w.word[hftu_pkg::CNT_MSB:hftu_pkg::CNT_LSB];
  wire in_desc = (st_r == ST_DESC);
  wire fire = w.word_valid && w.word_ready && ce;
  // Description words never need queue space, data words do.
  assign w.word_ready = in_desc || w.pair_ready; // RULE21
  assign w.pair_valid = w.word_valid && !in_desc;
  assign w.pair_data = w.word;
  // Indexed tags are group number joined to the in-group position.
  assign w.pair_tag = (st_r == ST_IDX) ?
    {tag_r[hftu_pkg::GRP_MSB:hftu_pkg::GRP_LSB], hftu_low_pos(mask_r)} :
    tag_r; // RULE2 RULE5 RULE6

  // Next-state decode for the three formats; value 3 is ignored.
  always_comb begin
    st_nxt = st_r;
    tag_nxt = tag_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    if (fire) begin
      case (st_r)
        ST_DESC: begin
          tag_nxt = w.word[8:0]; // RULE1 RULE4
          cnt_nxt = hi;
          mask_nxt = hi; // RULE3
          if (fmt == hftu_pkg::FMT_HOLD) begin
            st_nxt = ST_HOLD; // RULE23
          end else if (fmt == hftu_pkg::FMT_INC) begin
            st_nxt = ST_INC; // RULE24
          end else if (fmt == hftu_pkg::FMT_IDX && hi != 16'h0000) begin
            st_nxt = ST_IDX;
          end
        end
        ST_HOLD, ST_INC: begin
          if (st_r == ST_INC) begin
            tag_nxt = tag_r + 9'h001; // RULE24
          end
          cnt_nxt = cnt_r - 16'h0001;
          if (cnt_r == 16'h0000) begin
            st_nxt = ST_DESC;
          end
        end
        ST_IDX: begin
          mask_nxt = mask_r & (mask_r - 16'h0001); // RULE5 RULE6
          if (mask_nxt == 16'h0000) begin
            st_nxt = ST_DESC;
          end
        end
        default: st_nxt = ST_DESC;
      endcase
    end
  end

  // Sequence state; a bad code falls back to waiting for a description.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_DESC;
      tag_r <= 9'h000;
      cnt_r <= 16'h0000;
      mask_r <= 16'h0000;
    end else if (ce) begin
      st_r <= st_nxt;
      tag_r <= tag_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
    end
  end

  AST_IDX_GROUP: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    fire && in_desc && fmt == hftu_pkg::FMT_IDX && hi != 16'h0000 |=>
    st_r == ST_IDX && tag_r[8:4] == $past(w.word[8:4]))
    else $error("indexed group not taken from bits 8 to 4");
  AST_IDX_ORDER: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    fire && st_r == ST_IDX && ($past(st_r) != ST_IDX || $past(!fire)) |->
    mask_r[w.pair_tag[3:0]] && (mask_r & ((16'h0001 << w.pair_tag[3:0])
    - 16'h0001)) == 16'h0000)
    else $error("indexed data not in ascending tag order");
  AST_INC_STEP: assert property (@(posedge pclk) disable iff (!presetn) // RULE24
    fire && st_r == ST_INC && cnt_r != 16'h0000 |=>
    tag_r == $past(tag_r) + 9'h001)
    else $error("increment tag did not advance");
  AST_HOLD_TAG: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    fire && st_r == ST_HOLD && cnt_r != 16'h0000 |=>
    st_r == ST_HOLD && $stable(tag_r))
    else $error("hold tag changed inside a run");
  AST_FMT3: assert property (@(posedge pclk) disable iff (!presetn) // RULE27
    fire && in_desc && fmt == 2'h3 |=> st_r == ST_DESC)
    else $error("reserved format not ignored");
endmodule // hftu_unpack

// [rtl/hftu_top.sv]
// Host FIFO tag unpacker: APB port, DMA feed, input and output queues.
//
// Overview of operation
// RULE1: Register tags are nine bits wide.
// RULE2: Tag is five-bit group, four-bit position.
// RULE3: Format 2 takes upper half as mask.
// RULE4: Indexed group from bits 8..4, low ignored.
// RULE5: Set mask bits load matching group registers.
// RULE6: Data words follow mask in ascending order.
// RULE7: Word count drops per transferred item.
// RULE8: Count reaching zero raises DMA interrupt.
// RULE9: Interrupt only while its enable is set.
// RULE10: Flag records interrupt; writing one clears.
// RULE11: Output queue entries are 32 bits.
// RULE12: Input queue entry is 41-bit pair.
// RULE13: Two filter bits per category: tag, data.
// RULE14: Tag goes out before its data.
// RULE15: Full output queue stalls the producer.
// RULE16: Output word count is readable by host.
// RULE17: Host drains output, avoids input deadlock.
// RULE18: 1k-word window all acts as FIFO port.
// RULE19: Window read pops, window write feeds unpacker.
// RULE20: Raw writes unpack exactly like DMA words.
// RULE21: Description words consume no queue entry.
// RULE22: Host respects reported free input space.
// RULE23: Format 0 repeats one tag, count+1 words.
// RULE24: Format 1 advances tag per data word.
// RULE25: Writing word count starts DMA from base.
// RULE26: Free count tracks pushes and pops.
// RULE27: Format field bits 15..14; value 3 ignored.
// RULE28: Sixteen-entry input queue; DMA waits for room.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module hftu_top #(
  parameter int IN_DEPTH = 16,
  parameter int OUT_DEPTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic dma_rd_req,
  output logic [31:0] dma_rd_addr,
  input wire logic dma_rd_ack,
  input wire logic [31:0] dma_rd_data,
  output logic core_pair_valid,
  output logic [8:0] core_pair_tag,
  output logic [31:0] core_pair_data,
  input wire logic core_pair_ready,
  input wire logic out_valid,
  input wire logic [1:0] out_cat,
  input wire logic [8:0] out_tag,
  input wire logic [31:0] out_data,
  output logic out_ready,
  output logic dma_irq
);
  // Pointers need these widths.
  localparam int IAW = $clog2(IN_DEPTH);
  localparam int OAW = $clog2(OUT_DEPTH);
  localparam logic [IAW:0] IN_FULL = (IAW + 1)'(IN_DEPTH);
  localparam logic [OAW:0] OUT_FULL = (OAW + 1)'(OUT_DEPTH);

  hftu_word_if w ();

  // Input queue: 9-bit tag plus 32-bit data per entry.
  logic [40:0] in_mem [IN_DEPTH]; // RULE12 RULE28
  logic [IAW-1:0] in_wp_r, in_rp_r;
  logic [IAW:0] in_cnt_r;

  // Output queue: plain 32-bit words, tag or data.
  logic [31:0] out_mem [OUT_DEPTH]; // RULE11
  logic [OAW-1:0] out_wp_r, out_rp_r;
  logic [OAW:0] out_cnt_r;

  // Software-visible state.
  logic [31:0] dma_buffer_base_r;
  logic [31:0] dma_cur_addr_r;
  logic [15:0] dma_word_count_r;
  logic dma_done_irq_en_r;
  logic dma_done_flag_r;
  logic [7:0] output_category_filter_r;
  logic tag_sent_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // APB address decode; every word of the window is the same port.
  wire in_win = (paddr[hftu_pkg::FIFO_WIN_MSB:hftu_pkg::FIFO_WIN_LSB] ==
    hftu_pkg::FIFO_WIN_SEL); // RULE18
  wire hit_base = (paddr == hftu_pkg::DMA_BUFFER_BASE_OFS);
  wire hit_cnt = (paddr == hftu_pkg::DMA_WORD_COUNT_OFS);
  wire hit_ien = (paddr == hftu_pkg::IRQ_ENABLE_REG_OFS);
  wire hit_flg = (paddr == hftu_pkg::IRQ_FLAG_REG_OFS);
  wire hit_filt = (paddr == hftu_pkg::OUTPUT_CATEGORY_FILTER_OFS);
  wire hit_free = (paddr == hftu_pkg::INPUT_QUEUE_FREE_OFS);
  wire hit_owc = (paddr == hftu_pkg::OUTPUT_QUEUE_WORDS_OFS);
  wire mapped = in_win || hit_base || hit_cnt || hit_ien || hit_flg ||
    hit_filt || hit_free || hit_owc;

  // A running DMA owns the unpacker.
  wire dma_act = (dma_word_count_r != 16'h0000);
  wire acc = psel && penable;
  // Raw writes wait while DMA owns the unpacker or a data word meets a full input queue.
  wire raw_stall = acc && pwrite && in_win &&
    (dma_act || !w.word_ready);

  // Window writes can wait; with ce low every transfer waits.
  assign pready = ce && !raw_stall;
  assign pslverr = pready && acc && !mapped;
  wire apb_wr = pready && acc && pwrite && mapped;
  wire apb_rd = pready && acc && !pwrite;
  wire raw_wr = apb_wr && in_win; // RULE19 RULE20
  wire out_pop = apb_rd && in_win && out_cnt_r != '0; // RULE19
  wire wr_cnt = apb_wr && hit_cnt;
  wire flag_clr = apb_wr && hit_flg && pwdata[hftu_pkg::DMA_IRQ_BIT];

  // This is the room left to the host.
  wire [IAW:0] in_free = IN_FULL - in_cnt_r;

  // DMA pulls a word only when the unpacker can take it at once.
  assign dma_rd_req = ce && dma_act && w.word_ready; // RULE28
  assign dma_rd_addr = dma_cur_addr_r;

  // A word moves when both agree.
  wire dma_take = dma_rd_req && dma_rd_ack;
  wire dma_last = dma_take && dma_word_count_r == 16'h0001;
  // One word source at a time feeds the unpacker, DMA first.
  assign w.word_valid = dma_act ? dma_take : raw_wr; // RULE20
  assign w.word = dma_act ? dma_rd_data : pwdata;
  assign w.pair_ready = (in_cnt_r != IN_FULL);

  hftu_unpack u_unpack (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .w(w)
  );

  // Input queue handshakes toward the core.
  wire in_push = ce && w.pair_valid && w.pair_ready;
  wire in_pop = ce && core_pair_valid && core_pair_ready;
  assign core_pair_valid = (in_cnt_r != '0);
  assign core_pair_tag = in_mem[in_rp_r][40:32];
  assign core_pair_data = in_mem[in_rp_r][31:0];

  // Output filter: pick the category's two enable bits.
  wire [1:0] cat_en = output_category_filter_r[{out_cat, 1'b0} +: 2];
  wire en_tag = cat_en[hftu_pkg::FILT_TAG_BIT]; // RULE13
  wire en_dat = cat_en[hftu_pkg::FILT_DATA_BIT]; // RULE13

  // A full queue holds both halves.
  wire out_full = (out_cnt_r == OUT_FULL);
  wire push_tag = ce && out_valid && en_tag && !tag_sent_r && !out_full;
  wire push_dat = ce && out_valid && en_dat && (tag_sent_r || !en_tag) &&
    !out_full; // RULE14
  wire out_push = push_tag || push_dat;
  // The producer is held whenever its entry cannot enter the queue.
  assign out_ready = ce && ((!en_tag && !en_dat) || push_dat ||
    (push_tag && !en_dat)); // RULE15
  // Tags go out zero-extended.
  wire [31:0] out_word = push_tag ? {23'h000000, out_tag} : out_data;

  // Read data is captured in the setup cycle so prdata is a flop.
  always_comb begin
    prdata_nxt = hftu_pkg::RESET_WORD;
    if (in_win) begin
      prdata_nxt = out_mem[out_rp_r];
    end else if (hit_base) begin
      prdata_nxt = dma_buffer_base_r;
    end else if (hit_cnt) begin
      prdata_nxt = {16'h0000, dma_word_count_r};
    end else if (hit_ien) begin
      prdata_nxt = {31'h00000000, dma_done_irq_en_r};
    end else if (hit_flg) begin
      prdata_nxt = {31'h00000000, dma_done_flag_r};
    end else if (hit_filt) begin
      prdata_nxt = {24'h000000, output_category_filter_r};
    end else if (hit_free) begin
      prdata_nxt = 32'(in_free); // RULE26
    end else if (hit_owc) begin
      prdata_nxt = 32'(out_cnt_r); // RULE16
    end
  end
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= hftu_pkg::RESET_WORD;
    end else if (ce && psel && !penable) begin
      prdata_r <= prdata_nxt;
    end
  end

  // Software registers and the DMA counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_buffer_base_r <= hftu_pkg::RESET_WORD;
      dma_cur_addr_r <= hftu_pkg::RESET_WORD;
      dma_word_count_r <= 16'h0000;
      dma_done_irq_en_r <= 1'b0;
      output_category_filter_r <= 8'h00;
    end else if (ce) begin
      // Writes to plain registers land here.
      if (apb_wr && hit_base) begin
        dma_buffer_base_r <= pwdata;
      end
      if (apb_wr && hit_ien) begin
        dma_done_irq_en_r <= pwdata[hftu_pkg::DMA_IRQ_BIT];
      end
      if (apb_wr && hit_filt) begin
        output_category_filter_r <= pwdata[7:0];
      end
      // A count write restarts from the base held at that moment.
      if (wr_cnt) begin
        dma_word_count_r <= pwdata[15:0]; // RULE25
        dma_cur_addr_r <= dma_buffer_base_r; // RULE25
      end else if (dma_take) begin
        dma_word_count_r <= dma_word_count_r - 16'h0001; // RULE7
        dma_cur_addr_r <= dma_cur_addr_r + hftu_pkg::DMA_ADDR_STEP;
      end
    end
  end

  // Done flag: a new completion in the clearing cycle is kept.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_done_flag_r <= 1'b0;
    end else if (ce) begin
      if (dma_last && dma_done_irq_en_r) begin
        dma_done_flag_r <= 1'b1; // RULE8 RULE9 RULE10
      end else if (flag_clr) begin
        dma_done_flag_r <= 1'b0; // RULE10
      end
    end
  end
  // It stays up until cleared.
  assign dma_irq = dma_done_flag_r;

  // Input queue pointers and count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_wp_r <= '0;
      in_rp_r <= '0;
      in_cnt_r <= '0;
    end else begin
      if (in_push) begin
        in_wp_r <= in_wp_r + 1'b1;
      end
      if (in_pop) begin
        in_rp_r <= in_rp_r + 1'b1;
      end
      // The count tells full from empty.
      if (in_push && !in_pop) begin
        in_cnt_r <= in_cnt_r + 1'b1; // RULE26
      end else if (in_pop && !in_push) begin
        in_cnt_r <= in_cnt_r - 1'b1; // RULE26
      end
    end
  end

  // Queue storage has no reset; only the pointers matter.
  always_ff @(posedge pclk) begin
    if (in_push) begin
      in_mem[in_wp_r] <= {w.pair_tag, w.pair_data}; // RULE12
    end
    // It is a tag or data, as due.
    if (out_push) begin
      out_mem[out_wp_r] <= out_word;
    end
  end

  // Output queue pointers, count and tag/data phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_wp_r <= '0;
      out_rp_r <= '0;
      out_cnt_r <= '0;
      tag_sent_r <= 1'b0;
    end else begin
      if (out_push) begin
        out_wp_r <= out_wp_r + 1'b1;
      end
      if (out_pop) begin
        out_rp_r <= out_rp_r + 1'b1;
      end
      if (out_push && !out_pop) begin
        out_cnt_r <= out_cnt_r + 1'b1;
      end else if (out_pop && !out_push) begin
        out_cnt_r <= out_cnt_r - 1'b1;
      end
      // The tag half is already out.
      if (push_tag && en_dat) begin
        tag_sent_r <= 1'b1; // RULE14
      end else if (push_dat) begin
        tag_sent_r <= 1'b0;
      end
    end
  end

  // These check the top level.
  AST_DMA_DEC: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    dma_take && !wr_cnt |=> dma_word_count_r == $past(dma_word_count_r) -
    16'h0001)
    else $error("word count did not drop by one");

  AST_DMA_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    dma_last && dma_done_irq_en_r |=> dma_irq ##1 (dma_irq ||
    $past(flag_clr)))
    else $error("completion did not raise the flag");

  AST_IRQ_EN: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $rose(dma_done_flag_r) |-> $past(dma_done_irq_en_r) &&
    $past(dma_word_count_r) == 16'h0001)
    else $error("flag set without enable or completion");

  AST_FLAG_CLR: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    flag_clr && !dma_last |=> !dma_irq)
    else $error("flag not cleared by write of one");

  AST_TAG_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    push_tag && en_dat |=> !push_tag && out_mem[$past(out_wp_r)] ==
    {23'h000000, $past(out_tag)})
    else $error("tag not queued ahead of data");

  AST_FULL_STALL: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    out_full && out_valid && (en_tag || en_dat) |-> !out_ready &&
    !out_push)
    else $error("producer not stalled on full queue");

  AST_IN_FREE: assert property (@(posedge pclk) disable iff (!presetn) // RULE26
    in_push && !in_pop |=> in_free == $past(in_free) - 1'b1)
    else $error("free count wrong after a push");

  AST_DESC_NOSPACE: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    w.word_valid && w.word_ready && !w.pair_valid |=>
    in_cnt_r == $past(in_cnt_r) - (IAW + 1)'($past(in_pop)))
    else $error("description word took a queue entry");
endmodule // hftu_top

// [verification/hftu_host_mem.sv]
// Host memory model that serves the unpacker's DMA buffer reads.
`timescale 1ns/1ps
module hftu_host_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic dma_rd_req,
  input wire logic [31:0] dma_rd_addr,
  output logic dma_rd_ack,
  output logic [31:0] dma_rd_data
);
  logic [31:0] mem [16];
  logic [31:0] last_r;
  logic phase_r;
  // In slow mode only every other cycle answers, which stretches a transfer.
  assign dma_rd_ack = dma_rd_req && (!slow || phase_r);
  // Buffer words go out in buffer order; between answers the bus shows
  // the inverse of the last word so stale data can never pass as fresh.
  assign dma_rd_data = dma_rd_ack ? mem[dma_rd_addr[5:2]] : ~last_r;
  // Answer phase and last served word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 1'b0;
      last_r <= 32'h0000_0000;
    end else begin
      phase_r <= !phase_r;
      if (dma_rd_ack) begin
        last_r <= dma_rd_data;
      end
    end
  end
  // Lets the bench, acting as driver software, fill the buffer.
  task automatic load(input int idx, input logic [31:0] word);
    mem[idx] = word;
  endtask
endmodule // hftu_host_mem

// [verification/test_host_fifo_tag_unpacker.sv]
// Self-checking bench for the host FIFO tag unpacker.
`timescale 1ns/1ps
module test_host_fifo_tag_unpacker;
  localparam int OUTD = 4;
  localparam logic [15:0] A_BASE = hftu_pkg::DMA_BUFFER_BASE_OFS;
  localparam logic [15:0] A_CNT = hftu_pkg::DMA_WORD_COUNT_OFS;
  localparam logic [15:0] A_EN = hftu_pkg::IRQ_ENABLE_REG_OFS;
  localparam logic [15:0] A_FLAG = hftu_pkg::IRQ_FLAG_REG_OFS;
  localparam logic [15:0] A_FILT = hftu_pkg::OUTPUT_CATEGORY_FILTER_OFS;
  localparam logic [15:0] A_FREE = hftu_pkg::INPUT_QUEUE_FREE_OFS;
  localparam logic [15:0] A_WORDS = hftu_pkg::OUTPUT_QUEUE_WORDS_OFS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, dma_rd_req, dma_rd_ack, core_pair_valid;
  logic out_ready, dma_irq;
  logic [31:0] prdata, dma_rd_addr, dma_rd_data, core_pair_data;
  logic [8:0] core_pair_tag;
  logic core_pair_ready = 1'b0;
  logic out_valid = 1'b0;
  logic [1:0] out_cat = 2'h0;
  logic [8:0] out_tag = 9'h000;
  logic [31:0] out_data = 32'h0000_0000;
  logic slow = 1'b0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int checks = 0;
  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;
  // Design under test with a short output queue so filling it is cheap.
  hftu_top #(.IN_DEPTH(16), .OUT_DEPTH(OUTD)) hftu_top_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dma_rd_req(dma_rd_req), .dma_rd_addr(dma_rd_addr),
    .dma_rd_ack(dma_rd_ack), .dma_rd_data(dma_rd_data),
    .core_pair_valid(core_pair_valid), .core_pair_tag(core_pair_tag),
    .core_pair_data(core_pair_data), .core_pair_ready(core_pair_ready),
    .out_valid(out_valid), .out_cat(out_cat), .out_tag(out_tag),
    .out_data(out_data), .out_ready(out_ready), .dma_irq(dma_irq));
  // Host memory holding the DMA buffer.
  hftu_host_mem hftu_host_mem_i (
    .pclk(pclk), .presetn(presetn), .slow(slow), .dma_rd_req(dma_rd_req),
    .dma_rd_addr(dma_rd_addr), .dma_rd_ack(dma_rd_ack),
    .dma_rd_data(dma_rd_data));
  // Prints the verdict and ends the run.
  task automatic summarize;
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One clock edge of a bounded wait; a spent bound ends the run.
  task automatic tick(inout int n);
    @(posedge pclk);
    n++;
    if (n > 400) begin
      chk("wait bound", 32'h1, 32'h0);
      summarize();
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do tick(n); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [15:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask
  // Waits for the head pair, compares it, then pops it.
  task automatic pop_pair(input logic [8:0] t, input logic [31:0] d);
    int n;
    n = 0;
    do tick(n); while (core_pair_valid !== 1'b1);
    chk("pair tag", {23'h0, core_pair_tag}, {23'h0, t});
    chk("pair data", core_pair_data, d);
    core_pair_ready <= 1'b1;
    @(posedge pclk);
    core_pair_ready <= 1'b0;
  endtask
  // Offers one producer item and holds it until it is taken.
  task automatic prod(input logic [1:0] c, input logic [8:0] t,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    out_valid <= 1'b1;
    out_cat <= c;
    out_tag <= t;
    out_data <= d;
    do tick(n); while (out_ready !== 1'b1);
    out_valid <= 1'b0;
  endtask
  // Reset values and an unmapped access.
  task automatic t_reset;
    rdchk("free after reset", A_FREE, 32'h0000_0010);
    rdchk("out words after reset", A_WORDS, 32'h0000_0000);
    rdchk("count after reset", A_CNT, 32'h0000_0000);
    rdchk("flag after reset", A_FLAG, 32'h0000_0000);
    apb(1'b0, 16'h2000, 32'h0000_0000);
    chk("unmapped error", {31'h0, err}, 32'h0000_0001);
    chk("unmapped data", rd, 32'h0000_0000);
  endtask
  // Raw window writes in indexed, increment and hold formats.
  task automatic t_raw;
    wr(16'h0000, 32'h0032_80fa);
    rdchk("free after descriptor", A_FREE, 32'h0000_0010);
    wr(16'h0ffc, 32'h1111_0001);
    wr(16'h0400, 32'h1111_0002);
    wr(16'h0004, 32'h1111_0003);
    rdchk("free after three words", A_FREE, 32'h0000_000d);
    pop_pair(9'h0f1, 32'h1111_0001);
    pop_pair(9'h0f4, 32'h1111_0002);
    pop_pair(9'h0f5, 32'h1111_0003);
    wr(16'h0000, 32'h0001_4020);
    wr(16'h0000, 32'h2222_0001);
    wr(16'h0000, 32'h2222_0002);
    pop_pair(9'h020, 32'h2222_0001);
    pop_pair(9'h021, 32'h2222_0002);
    wr(16'h0000, 32'h0000_01ff);
    wr(16'h0000, 32'h3333_0001);
    pop_pair(9'h1ff, 32'h3333_0001);
  endtask
  // DMA with the interrupt enabled, then disabled with a slow memory.
  task automatic t_dma;
    int n;
    hftu_host_mem_i.load(0, 32'h0001_0055);
    hftu_host_mem_i.load(1, 32'ha5a5_0001);
    hftu_host_mem_i.load(2, 32'ha5a5_0002);
    wr(A_EN, 32'h0000_0001);
    wr(A_BASE, 32'h0000_0100);
    wr(A_CNT, 32'h0000_0003);
    n = 0;
    do tick(n); while (dma_irq !== 1'b1);
    rdchk("count at end", A_CNT, 32'h0000_0000);
    rdchk("flag at end", A_FLAG, 32'h0000_0001);
    pop_pair(9'h055, 32'ha5a5_0001);
    pop_pair(9'h055, 32'ha5a5_0002);
    wr(A_FLAG, 32'h0000_0001);
    rdchk("flag after clear", A_FLAG, 32'h0000_0000);
    chk("irq after clear", {31'h0, dma_irq}, 32'h0000_0000);
    slow <= 1'b1;
    wr(A_EN, 32'h0000_0000);
    hftu_host_mem_i.load(3, 32'h0000_0066);
    hftu_host_mem_i.load(4, 32'h1234_5678);
    wr(A_BASE, 32'h0000_010c);
    wr(A_CNT, 32'h0000_0002);
    n = 0;
    do begin
      apb(1'b0, A_CNT, 32'h0000_0000);
      tick(n);
    end while (rd !== 32'h0000_0000);
    chk("irq while disabled", {31'h0, dma_irq}, 32'h0000_0000);
    rdchk("flag while disabled", A_FLAG, 32'h0000_0000);
    pop_pair(9'h066, 32'h1234_5678);
    slow <= 1'b0;
  endtask
  // Output filtering, tag before data, and a full output queue.
  task automatic t_out;
    int n;
    wr(A_FILT, 32'h0000_0030);
    rdchk("filter readback", A_FILT, 32'h0000_0030);
    prod(2'h2, 9'h123, 32'hdead_beef);
    rdchk("out words tag and data", A_WORDS, 32'h0000_0002);
    rdchk("first out word", 16'h0000, 32'h0000_0123);
    rdchk("second out word", 16'h0ff0, 32'hdead_beef);
    wr(A_FILT, 32'h0000_0001);
    prod(2'h0, 9'h0ab, 32'h0000_0001);
    rdchk("out words tag only", A_WORDS, 32'h0000_0001);
    rdchk("tag only word", 16'h0000, 32'h0000_00ab);
    wr(A_FILT, 32'h0000_0080);
    for (int i = 0; i < OUTD; i++) begin
      prod(2'h3, 9'h000, 32'h5000_0000 + i);
    end
    rdchk("out words full", A_WORDS, OUTD);
    @(posedge pclk);
    out_valid <= 1'b1;
    out_data <= 32'h5000_00ff;
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      chk("stall while full", {31'h0, out_ready}, 32'h0000_0000);
    end
    rdchk("pop while full", 16'h0000, 32'h5000_0000);
    n = 0;
    do tick(n); while (out_ready !== 1'b1);
    out_valid <= 1'b0;
    for (int i = 1; i < OUTD; i++) begin
      rdchk("drain word", 16'h0000, 32'h5000_0000 + i);
    end
    rdchk("resumed word", 16'h0000, 32'h5000_00ff);
    rdchk("out words drained", A_WORDS, 32'h0000_0000);
  endtask
  // Reset, then every scenario in turn.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_raw();
    t_dma();
    t_out();
    summarize();
  end
endmodule // test_host_fifo_tag_unpacker
